// ===== rtl/rt_mode_option_config.sv
// RT option configuration bits, self-test word selection and receive staging buffer
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module rt_mode_option_config #(
    parameter int depth = 32
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire rt_option_pkg::rt_cmd_t cmd,
    input wire rt_option_pkg::rt_word_t rx_word,
    input wire logic msg_done,
    input wire logic msg_error,
    input wire logic [3:0] shutdown_status,
    output rt_option_pkg::rt_word_t bit_word_out,
    output logic simplified_mode_out,
    output rt_option_pkg::rt_mem_write_t mem_write,
    output logic rt_execution_enable
);
    logic [15:0] option_ff, nxt_option;
    logic [15:0] alt_word_ff, nxt_alt_word;
    logic [11:0] selftest_sw_ff, nxt_selftest_sw;
    logic exec_ff, nxt_exec;
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    rt_option_pkg::rt_word_t bitw_ff, nxt_bitw;
    logic simple_ff, nxt_simple;
    rt_option_pkg::stage_state_t state_ff, nxt_state;
    logic [15:0] buf_mem [depth];
    logic [4:0] count_ff, nxt_count;
    logic [4:0] rd_ff, nxt_rd;
    logic [4:0] sa_ff, nxt_sa;
    logic [5:0] fill_ff, nxt_fill;
    rt_option_pkg::rt_mem_write_t mw_ff, nxt_mw;
    logic buf_we;
    logic [15:0] selftest_word;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // Default word: device status in high nibble, software bits below
    assign selftest_word = {shutdown_status, selftest_sw_ff};

    // Register bus
    always_comb begin
        nxt_option = option_ff;
        nxt_alt_word = alt_word_ff;
        nxt_selftest_sw = selftest_sw_ff;
        nxt_exec = exec_ff;
        nxt_rdata = rdata_ff;
        nxt_wait = 1'b1;
        if (read || write) begin
            // One wait cycle, then waitrequest low for one cycle
            nxt_wait = !wait_ff;
            // Writes land at the edge that sees waitrequest low
            if (write && !wait_ff) begin
                if (hit(address, rt_option_pkg::option_config_addr)) begin
                    nxt_option = writedata[15:0];
                    // Staging bit only follows a write while execution is off
                    if (exec_ff) begin
                        nxt_option[rt_option_pkg::staging_bit] = option_ff[rt_option_pkg::staging_bit];
                    end
                end else if (hit(address, rt_option_pkg::alt_selftest_word_addr)) begin
                    nxt_alt_word = writedata[15:0];
                end else if (hit(address, rt_option_pkg::selftest_word_addr)) begin
                    nxt_selftest_sw = writedata[11:0];
                end else if (hit(address, rt_option_pkg::exec_ctrl_addr)) begin
                    nxt_exec = writedata[0];
                end
            end else if (read && wait_ff) begin
                nxt_rdata = 32'h0000_0000;
                if (hit(address, rt_option_pkg::option_config_addr)) begin
                    nxt_rdata[15:0] = option_ff;
                end else if (hit(address, rt_option_pkg::alt_selftest_word_addr)) begin
                    nxt_rdata[15:0] = alt_word_ff;
                end else if (hit(address, rt_option_pkg::selftest_word_addr)) begin
                    nxt_rdata[15:0] = selftest_word;
                end else if (hit(address, rt_option_pkg::exec_ctrl_addr)) begin
                    nxt_rdata[0] = exec_ff;
                end else if (hit(address, rt_option_pkg::bus_status_addr)) begin
                    nxt_rdata[1:0] = state_ff == rt_option_pkg::st_idle ? 2'h0 : 2'h1;
                    nxt_rdata[13:8] = fill_ff;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            option_ff <= rt_option_pkg::option_config_reset;
            alt_word_ff <= rt_option_pkg::alt_word_reset;
            selftest_sw_ff <= 12'h000;
            exec_ff <= 1'b0;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            option_ff <= nxt_option;
            alt_word_ff <= nxt_alt_word;
            selftest_sw_ff <= nxt_selftest_sw;
            exec_ff <= nxt_exec;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;
    assign rt_execution_enable = exec_ff;

    // Mode command answer
    always_comb begin
        nxt_bitw = '0;
        nxt_simple = 1'b0;
        if (cmd.valid && cmd.is_mode) begin
            nxt_simple = option_ff[rt_option_pkg::simple_mode_bit];
            // Transmit direction with the BIT word mode code
            if (!cmd.is_receive && {1'b0, cmd.code} == rt_option_pkg::mode_code_bit_word) begin
                nxt_bitw.valid = 1'b1;
                nxt_bitw.data = option_ff[rt_option_pkg::alt_bit] ? alt_word_ff : selftest_word;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bitw_ff <= '0;
            simple_ff <= 1'b0;
        end else begin
            bitw_ff <= nxt_bitw;
            simple_ff <= nxt_simple;
        end
    end

    assign bit_word_out = bitw_ff;
    assign simplified_mode_out = simple_ff;

    // Receive staging
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_rd = rd_ff;
        nxt_sa = sa_ff;
        nxt_fill = fill_ff;
        nxt_mw = '0;
        buf_we = 1'b0;
        case (state_ff)
            rt_option_pkg::st_idle: begin
                if (cmd.valid && cmd.is_receive && !cmd.is_mode) begin
                    nxt_sa = cmd.subaddr;
                    nxt_count = 5'h00;
                    nxt_fill = 6'h00;
                    nxt_state = rt_option_pkg::st_collect;
                end
            end
            rt_option_pkg::st_collect: begin
                if (rx_word.valid) begin
                    if (option_ff[rt_option_pkg::staging_bit]) begin
                        buf_we = fill_ff < 6'(depth);
                    end else begin
                        nxt_mw = '{valid: 1'b1, subaddr: sa_ff, index: count_ff, data: rx_word.data};
                    end
                    nxt_count = count_ff + 5'h01;
                    nxt_fill = fill_ff < 6'(depth) ? fill_ff + 6'h01 : fill_ff;
                end
                if (msg_done) begin
                    nxt_rd = 5'h00;
                    if (!option_ff[rt_option_pkg::staging_bit] || msg_error || fill_ff == 6'h00) begin
                        nxt_fill = 6'h00;
                        nxt_state = rt_option_pkg::st_idle;
                    end else begin
                        nxt_state = rt_option_pkg::st_copy;
                    end
                end
            end
            rt_option_pkg::st_copy: begin
                nxt_mw = '{valid: 1'b1, subaddr: sa_ff, index: rd_ff, data: buf_mem[rd_ff]};
                nxt_rd = rd_ff + 5'h01;
                nxt_fill = fill_ff - 6'h01;
                if (fill_ff == 6'h01) begin
                    nxt_state = rt_option_pkg::st_idle;
                end
            end
            default: nxt_state = rt_option_pkg::st_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (buf_we) begin
            buf_mem[count_ff] <= rx_word.data;
        end
        if (!rstn) begin
            state_ff <= rt_option_pkg::st_idle;
            count_ff <= 5'h00;
            rd_ff <= 5'h00;
            sa_ff <= 5'h00;
            fill_ff <= 6'h00;
            mw_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            rd_ff <= nxt_rd;
            sa_ff <= nxt_sa;
            fill_ff <= nxt_fill;
            mw_ff <= nxt_mw;
        end
    end

    assign mem_write = mw_ff;
endmodule

// ===== rtl/rt_option_pkg.sv
// Package with register map, field positions and types for the RT option block
package rt_option_pkg;
    localparam logic [7:0] option_config_addr = 8'h1d;
    localparam logic [7:0] selftest_word_addr = 8'h1e;
    localparam logic [7:0] alt_selftest_word_addr = 8'h1f;
    localparam logic [7:0] exec_ctrl_addr = 8'h1c;
    localparam logic [7:0] bus_status_addr = 8'h1b;
    localparam int simple_mode_bit = 7;
    localparam int staging_bit = 6;
    localparam int alt_bit = 5;
    localparam int staging_depth = 32;
    localparam logic [15:0] option_config_reset = 16'h0000;
    localparam logic [15:0] alt_word_reset = 16'h0000;
    localparam logic [15:0] selftest_sw_mask = 16'h0fff;
    localparam logic [5:0] mode_code_bit_word = 6'h13;

    typedef struct packed {
        logic valid;
        logic is_mode;
        logic is_receive;
        logic [4:0] subaddr;
        logic [4:0] code;
    } rt_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } rt_word_t;

    typedef struct packed {
        logic valid;
        logic [4:0] subaddr;
        logic [4:0] index;
        logic [15:0] data;
    } rt_mem_write_t;

    typedef enum logic [1:0] {
        st_idle,
        st_collect,
        st_copy
    } stage_state_t;
endpackage

// ===== test/bc_cmd_model.sv
// Bus controller model issuing decoded commands and data words
`timescale 1ns/1ps
module bc_cmd_model (
    input wire logic clock,
    output rt_option_pkg::rt_cmd_t cmd,
    output rt_option_pkg::rt_word_t rx_word,
    output logic msg_done,
    output logic msg_error
);
    initial begin
        cmd = '0;
        rx_word = '{1'b0, 16'h5a5a};
        msg_done = 1'b0;
        msg_error = 1'b0;
    end
    task automatic mode_cmd(input logic [4:0] c);
        cmd <= '{1'b1, 1'b1, 1'b0, 5'h1f, c};
        @(posedge clock);
        cmd <= '0;
    endtask
    task automatic rx_msg(input logic [4:0] sa, input int n, input logic [15:0] base, input logic err, input logic slow);
        cmd <= '{1'b1, 1'b0, 1'b1, sa, 5'h0};
        @(posedge clock);
        cmd <= '0;
        for (int i = 0; i < n; i++) begin
            rx_word <= '{1'b1, 16'(base + i)};
            @(posedge clock);
            if (slow) begin
                rx_word <= '{1'b0, ~rx_word.data};
                @(posedge clock);
            end
        end
        rx_word <= '{1'b0, ~rx_word.data};
        msg_done <= 1'b1;
        msg_error <= err;
        @(posedge clock);
        msg_done <= 1'b0;
        msg_error <= 1'b0;
    endtask
endmodule

// ===== test/rt_mode_option_config_tb.sv
// Self-checking bench for the RT option block
`timescale 1ns/1ps
module rt_mode_option_config_tb;
    logic clock = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
    logic [7:0] address = 8'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [3:0] shutdown_status = 4'h0;
    logic waitrequest, msg_done, msg_error, simplified_mode_out, rt_execution_enable;
    logic [15:0] d, b;
    rt_option_pkg::rt_cmd_t cmd;
    rt_option_pkg::rt_word_t rx_word, bit_word_out;
    rt_option_pkg::rt_mem_write_t mem_write;
    rt_option_pkg::rt_mem_write_t got[$];
    int mismatches = 0, cmp_count = 0, seed = 69018, n;
    always #5 clock = ~clock;
    always @(posedge clock) if (mem_write.valid === 1'b1) got.push_back(mem_write);
    rt_mode_option_config rt_mode_option_config_inst (.clock(clock), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .cmd(cmd),
        .rx_word(rx_word), .msg_done(msg_done), .msg_error(msg_error), .shutdown_status(shutdown_status),
        .bit_word_out(bit_word_out), .simplified_mode_out(simplified_mode_out), .mem_write(mem_write),
        .rt_execution_enable(rt_execution_enable));
    bc_cmd_model bc_cmd_model_inst (.clock(clock), .cmd(cmd), .rx_word(rx_word), .msg_done(msg_done),
        .msg_error(msg_error));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] v);
        int k;
        k = 0;
        address <= a;
        write <= w;
        read <= !w;
        writedata <= {16'h0, v};
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        if (k >= 20) mismatches++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        results;
    end
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        shutdown_status <= 4'($random(seed));
        @(posedge clock);
        bus(8'h1d, 1'b0, 16'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            // Word registers, unmapped place, then every simplified and alternate bit combination, staging off
            d = 16'($random(seed));
            bus(8'h1e, 1'b1, d);
            bus(8'h1f, 1'b1, ~d);
            bus(8'h05, 1'b1, d);
            bus(8'h1e, 1'b0, 16'h0);
            chk(q, {16'h0, shutdown_status, d[11:0]});
            bus(8'h1f, 1'b0, 16'h0);
            chk(q, {16'h0, ~d});
            bus(8'h05, 1'b0, 16'h0);
            chk(q, 32'h0);
            bus(8'h1d, 1'b1, {8'h0, i[1], 1'b0, i[0], 5'h0});
            bc_cmd_model_inst.mode_cmd(5'h13);
            @(posedge clock);
            chk({bit_word_out, simplified_mode_out}, {1'b1, i[0] ? ~d : {shutdown_status, d[11:0]}, i[1]});
            bc_cmd_model_inst.mode_cmd(5'h02);
            @(posedge clock);
            chk({bit_word_out.valid, simplified_mode_out}, {1'b0, i[1]});
            $display("mode test %0d done", i);
        end
        bus(8'h1c, 1'b1, 16'h1);
        chk(rt_execution_enable, 32'h1);
        bus(8'h1d, 1'b1, 16'h40);
        bus(8'h1d, 1'b0, 16'h0);
        chk(q, 32'h0);
        for (int t = 0; t < 4; t++) begin
            // Direct, staged, staged full with stalls, staged with error
            bus(8'h1c, 1'b1, 16'h0);
            bus(8'h1d, 1'b1, {9'h0, t > 0, 6'h0});
            bus(8'h1d, 1'b0, 16'h0);
            chk(q, {25'h0, t > 0, 6'h0});
            bus(8'h1c, 1'b1, 16'h1);
            got.delete();
            b = 16'($random(seed));
            bc_cmd_model_inst.rx_msg(5'(t + 3), t == 2 ? 32 : 5, b, t == 3, t == 2);
            n = 0;
            do begin
                bus(8'h1b, 1'b0, 16'h0);
                n++;
            end while (q[0] !== 1'b0 && n < 60);
            if (n >= 60) mismatches++;
            repeat (3) @(posedge clock);
            chk(got.size(), t == 3 ? 0 : (t == 2 ? 32 : 5));
            foreach (got[k]) chk(got[k], {1'b1, 5'(t + 3), 5'(k), 16'(b + k)});
            $display("receive test %0d done", t);
        end
        results;
    end
endmodule

// ===== test/rt_option_assertions.sv
// Concurrent checks for the RT option block
`timescale 1ns/1ps
module rt_option_assertions (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire rt_option_pkg::rt_cmd_t cmd,
    input wire rt_option_pkg::rt_word_t rx_word,
    input wire logic msg_done,
    input wire logic msg_error,
    input wire rt_option_pkg::rt_word_t bit_word_out,
    input wire logic simplified_mode_out,
    input wire rt_option_pkg::rt_mem_write_t mem_write,
    input wire logic rt_execution_enable
);
    logic simple_ff, stg_ff, sel_ff, bitcmd;
    logic [15:0] alt_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    assign bitcmd = cmd.valid && cmd.is_mode && !cmd.is_receive && cmd.code == 5'h13;
    // Mirror of the option bits and the alternate word
    always_ff @(posedge clock) begin
        if (!rstn) begin
            simple_ff <= 1'b0;
            stg_ff <= 1'b0;
            sel_ff <= 1'b0;
            alt_ff <= 16'h0;
        end else if (write && !waitrequest) begin
            if (address == rt_option_pkg::option_config_addr) begin
                simple_ff <= writedata[7];
                sel_ff <= writedata[5];
                if (!rt_execution_enable) stg_ff <= writedata[6];
            end
            if (address == rt_option_pkg::alt_selftest_word_addr) alt_ff <= writedata[15:0];
        end
    end
    ack_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
    smode_pulse_a: assert property (cmd.valid && cmd.is_mode |=> simplified_mode_out == simple_ff)
        else $error("simplified flag wrong");
    bit_answer_a: assert property (bitcmd |=> bit_word_out.valid) else $error("no test word answer");
    alt_word_a: assert property (bitcmd && sel_ff |=> bit_word_out.data == alt_ff)
        else $error("alternate word wrong");
    stage_hold_a: assert property (stg_ff && rx_word.valid |=> !mem_write.valid) else $error("staged word leaked");
    direct_write_a: assert property (!stg_ff && rx_word.valid |=>
        mem_write.valid && mem_write.data == $past(rx_word.data)) else $error("direct word missing");
    copy_start_a: assert property (stg_ff && msg_done && !msg_error |->
        ##2 mem_write.valid && mem_write.index == 5'h0) else $error("copy did not start");
    err_discard_a: assert property (stg_ff && msg_done && msg_error |->
        ##1 !mem_write.valid [*8]) else $error("errored message copied");
    cover property (stg_ff && msg_done && !msg_error);
    cover property (stg_ff && msg_done && msg_error);
    cover property (bitcmd && sel_ff);
endmodule

bind rt_mode_option_config rt_option_assertions rt_option_assertions_inst (.clock(clock), .rstn(rstn),
    .address(address), .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest), .cmd(cmd),
    .rx_word(rx_word), .msg_done(msg_done), .msg_error(msg_error), .bit_word_out(bit_word_out),
    .simplified_mode_out(simplified_mode_out), .mem_write(mem_write), .rt_execution_enable(rt_execution_enable));
